/* File: src/mwsl_pkg.sv */
// Shared constants and types of the multichannel wiper serial loader
package mwsl_pkg;

  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int          WORD_W     = 11;
  localparam int          DATA_W     = 8;
  localparam int          ADDR_W     = 3;
  localparam int          ADDR_LSB   = 8;
  localparam int          ADDR_MSB   = 10;
  localparam int          DATA_MSB   = 7;
  localparam int          CHAIN_MSB  = 10;

  // ----------------------------------------------------------------
  // Channels and reset values
  // ----------------------------------------------------------------
  localparam int          NUM_CH     = 6;
  localparam int          BANK_W     = NUM_CH * DATA_W;
  localparam logic [2:0]  CH_FOUR    = 3'h4;
  localparam logic [2:0]  CH_SIX     = 3'h6;
  localparam logic [7:0]  MIDSCALE   = 8'h80;
  localparam logic [10:0] WORD_RST   = 11'h000;

  // ----------------------------------------------------------------
  // Synchroniser layout: select, preset, power down, chain bit
  // ----------------------------------------------------------------
  localparam int          SYNC_W     = 4;
  localparam int          S_SEL      = 3;
  localparam int          S_PRE      = 2;
  localparam int          S_PD       = 1;
  localparam int          S_CHAIN    = 0;
  localparam logic [3:0]  SYNC_RST   = 4'hE;

  // Frame tracking, Gray coded along idle, frame, load
  typedef enum logic [1:0] {
    MWSL_IDLE  = 2'b00,
    MWSL_FRAME = 2'b01,
    MWSL_LOAD  = 2'b11
  } mwsl_state_t;

endpackage

/* File: src/mwsl_sync.sv */
// Two-stage level synchroniser, one per bit
`timescale 1ns/100ps
module mwsl_sync #(
  parameter int                 W       = 1,
  parameter logic [W-1:0]       RST_VAL = '0
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // Level in and out
  input  wire logic [W-1:0]     d,
  output logic      [W-1:0]     q
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] nxt_meta_ff;
  logic [W-1:0] nxt_sync_ff;

  // First stage feeds only the second stage
  always_comb begin
    nxt_meta_ff = d;
    nxt_sync_ff = meta_ff;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= nxt_meta_ff;
      sync_ff <= nxt_sync_ff;
    end
  end

  assign q = sync_ff;

endmodule

/* File: src/mwsl_wiper_bank.sv */
// Bank of wiper latches with one write port and a preset to midscale
`timescale 1ns/100ps
module mwsl_wiper_bank
  import mwsl_pkg::*;
(
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       resetn,
  // Control
  input  wire logic                       preset_all,
  input  wire logic                       wr_en,
  input  wire logic [mwsl_pkg::ADDR_W-1:0] wr_addr,
  input  wire logic [mwsl_pkg::DATA_W-1:0] wr_data,
  // All latches, channel 0 in the low byte
  output logic      [mwsl_pkg::BANK_W-1:0] wiper_flat
);

  logic [DATA_W-1:0] mem_ff     [NUM_CH];
  logic [DATA_W-1:0] nxt_mem_ff [NUM_CH];

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      nxt_mem_ff[i] = mem_ff[i];
      if (preset_all) begin
        nxt_mem_ff[i] = MIDSCALE;
      end else if (wr_en && (wr_addr == i[ADDR_W-1:0])) begin
        nxt_mem_ff[i] = wr_data;
      end
    end
  end

  // Power-on value is midscale without any command
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_CH; i++) begin
        mem_ff[i] <= MIDSCALE; // RULE16
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        mem_ff[i] <= nxt_mem_ff[i];
      end
    end
  end

  for (genvar g = 0; g < NUM_CH; g++) begin : g_out
    assign wiper_flat[g*DATA_W +: DATA_W] = mem_ff[g];
  end

endmodule

/* File: src/mwsl_loader.sv */
// Serial loader top: shift chain on the link clock, latches on clk
// Behaviour
// (RULE1) Shift data in on clock rise while selected
// (RULE2) Chain output gives bit from eleven edges back
// (RULE3) Select low, clock low: hold, enable output
// (RULE4) Select rise loads addressed latch when enabled
// (RULE5) Last eleven bits kept for the update
// (RULE6) Codes zero to five pick latches one-six
// (RULE7) Latch takes low eight bits of word
// (RULE8) Controller sends one word per channel
// (RULE9) Preset low forces midscale, clears chain latch
// (RULE10) Preset rise with select high loads midscale
// (RULE11) Power down opens terminals, releases chain output
// (RULE12) Chain output only pulls low or releases
// (RULE13) Controller holds select through whole chain
// (RULE14) Controller slows clock for pulled-up chain
// (RULE15) Word is address then value, MSB first
// (RULE16) Power-up puts every latch at midscale
// (RULE17) Power down keeps latch contents
// (RULE18) Missing channel address changes nothing
`timescale 1ns/100ps
module mwsl_loader #(
  parameter bit                            SIX_CHANNEL = 1'b1
) (
  // System clock and reset
  input  wire logic                        clk,
  input  wire logic                        resetn,
  // Serial link
  input  wire logic                        sclk,
  input  wire logic                        cs_n,
  input  wire logic                        serial_in,
  output logic                             chain_out_o,
  output logic                             chain_out_oe,
  // Static controls
  input  wire logic                        preset_n,
  input  wire logic                        power_down_n,
  // Analog switch controls and wiper codes
  output logic                             terminal_a_open,
  output logic                             wiper_to_b,
  output logic [mwsl_pkg::BANK_W-1:0]      wiper_value
);
  import mwsl_pkg::*;

  // ----------------------------------------------------------------
  // Link clock domain
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] sr_ff;
  logic [WORD_W-1:0] nxt_sr_ff;
  logic              chain_ff;
  logic              nxt_chain_ff;
  logic              link_rst_n;

  // Preset acts without the link clock, which may stand still
  assign link_rst_n = resetn & preset_n;

  always_comb begin
    nxt_sr_ff = sr_ff; // RULE3
    if (!cs_n) begin
      nxt_sr_ff = {sr_ff[WORD_W-2:0], serial_in}; // RULE1 RULE15
    end
  end

  always_ff @(posedge sclk or negedge resetn) begin
    if (!resetn) begin
      sr_ff <= WORD_RST;
    end else begin
      sr_ff <= nxt_sr_ff;
    end
  end

  always_comb begin
    nxt_chain_ff = chain_ff;
    if (!cs_n) begin
      nxt_chain_ff = sr_ff[CHAIN_MSB]; // RULE2
    end
  end

  always_ff @(posedge sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      chain_ff <= 1'b0; // RULE9
    end else begin
      chain_ff <= nxt_chain_ff;
    end
  end

  // ----------------------------------------------------------------
  // Crossing into the system clock
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] sync_q;
  logic              cs_s;
  logic              pre_s;
  logic              pd_s;
  logic              chain_s;

  mwsl_sync #(
    .W       (SYNC_W),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .clk     (clk),
    .resetn  (resetn),
    .d       ({cs_n, preset_n, power_down_n, chain_ff}),
    .q       (sync_q)
  );

  assign cs_s    = sync_q[S_SEL];
  assign pre_s   = sync_q[S_PRE];
  assign pd_s    = sync_q[S_PD];
  assign chain_s = sync_q[S_CHAIN];

  // ----------------------------------------------------------------
  // Frame tracking and word capture
  // ----------------------------------------------------------------
  mwsl_state_t       state_ff;
  mwsl_state_t       nxt_state_ff;
  logic [WORD_W-1:0] word_ff;
  logic [WORD_W-1:0] nxt_word_ff;
  logic              pre_prev_ff;
  logic              nxt_pre_prev_ff;

  // Shift chain is quiet while select is high, so the word is
  // stable by the time the synchronised select rise is seen
  always_comb begin
    nxt_state_ff    = state_ff;
    nxt_word_ff     = word_ff;
    nxt_pre_prev_ff = pre_s;
    case (state_ff)
      MWSL_IDLE: begin
        if (!cs_s) begin
          nxt_state_ff = MWSL_FRAME;
        end
      end
      MWSL_FRAME: begin
        if (cs_s) begin
          nxt_state_ff = MWSL_LOAD;
          nxt_word_ff  = sr_ff; // RULE5
        end
      end
      MWSL_LOAD: begin
        nxt_state_ff = cs_s ? MWSL_IDLE : MWSL_FRAME;
      end
      default: begin
        nxt_state_ff = MWSL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff    <= MWSL_IDLE;
      word_ff     <= WORD_RST;
      pre_prev_ff <= 1'b1;
    end else begin
      state_ff    <= nxt_state_ff;
      word_ff     <= nxt_word_ff;
      pre_prev_ff <= nxt_pre_prev_ff;
    end
  end

  // ----------------------------------------------------------------
  // Address decode and latch bank
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] word_addr;
  logic [DATA_W-1:0] word_data;
  logic [2:0]        ch_count;
  logic              addr_ok;
  logic              load_go;
  logic              preset_all;

  assign word_addr = word_ff[ADDR_MSB:ADDR_LSB];
  assign word_data = word_ff[DATA_MSB:0]; // RULE7
  assign ch_count  = SIX_CHANNEL ? CH_SIX : CH_FOUR;
  assign addr_ok   = (word_addr < ch_count); // RULE6 RULE18
  // Load is refused under preset or power down
  assign load_go   = (state_ff == MWSL_LOAD) && pre_s && pd_s
                     && addr_ok; // RULE4
  assign preset_all = !pre_s // RULE9
                      || (!pre_prev_ff && cs_s); // RULE10

  // Power down never writes the bank, so codes survive it
  mwsl_wiper_bank u_bank (
    .clk        (clk),
    .resetn     (resetn),
    .preset_all (preset_all),
    .wr_en      (load_go), // RULE17
    .wr_addr    (word_addr),
    .wr_data    (word_data),
    .wiper_flat (wiper_value)
  );

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  logic out_lvl_ff;
  logic out_oe_ff;
  logic a_open_ff;
  logic to_b_ff;
  logic nxt_out_oe_ff;
  logic nxt_a_open_ff;
  logic nxt_to_b_ff;

  // Daisy chain output lags the link by the synchroniser delay plus one output register
  always_comb begin
    nxt_out_oe_ff = !cs_s && pd_s && !chain_s; // RULE3 RULE11 RULE12
    nxt_a_open_ff = !pd_s; // RULE11
    nxt_to_b_ff   = !pd_s; // RULE11
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      out_lvl_ff <= 1'b0;
      out_oe_ff  <= 1'b0;
      a_open_ff  <= 1'b0;
      to_b_ff    <= 1'b0;
    end else begin
      out_lvl_ff <= 1'b0; // RULE12
      out_oe_ff  <= nxt_out_oe_ff;
      a_open_ff  <= nxt_a_open_ff;
      to_b_ff    <= nxt_to_b_ff;
    end
  end

  assign chain_out_o     = out_lvl_ff;
  assign chain_out_oe    = out_oe_ff;
  assign terminal_a_open = a_open_ff;
  assign wiper_to_b      = to_b_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] sel_wiper;
  logic              all_mid;

  assign sel_wiper = wiper_value[{word_addr, 3'b000} +: DATA_W];

  always_comb begin
    all_mid = 1'b1;
    for (int i = 0; i < NUM_CH; i++) begin
      if (wiper_value[i*DATA_W +: DATA_W] != MIDSCALE) begin
        all_mid = 1'b0;
      end
    end
  end

  property p_shift;
    @(posedge sclk) disable iff (!resetn)
      !cs_n |=> (sr_ff[0] == $past(serial_in))
                && (sr_ff[WORD_W-1:1] == $past(sr_ff[WORD_W-2:0]));
  endproperty
  a_shift: assert property (p_shift) // RULE1
    else $error("shift chain did not take input bit");

  property p_chain;
    @(posedge sclk) disable iff (!link_rst_n)
      !cs_n |=> chain_ff == $past(sr_ff[CHAIN_MSB], 1);
  endproperty
  a_chain: assert property (p_chain) // RULE2
    else $error("chain bit is not the eleventh bit back");

  // Preset clears the chain bit between link edges, so it aborts too
  property p_hold;
    @(posedge sclk) disable iff (!link_rst_n)
      cs_n |=> $stable(sr_ff) && $stable(chain_ff);
  endproperty
  a_hold: assert property (p_hold) // RULE3
    else $error("shift chain moved while deselected");

  property p_capture;
    @(posedge clk) disable iff (!resetn)
      (state_ff == MWSL_FRAME) && cs_s
        |=> (state_ff == MWSL_LOAD) && (word_ff == $past(sr_ff));
  endproperty
  a_capture: assert property (p_capture) // RULE5
    else $error("word not captured on select rise");

  property p_load;
    @(posedge clk) disable iff (!resetn)
      load_go && !preset_all |=> sel_wiper == $past(word_data);
  endproperty
  a_load: assert property (p_load) // RULE4
    else $error("addressed latch did not load low byte");

  property p_bad_addr;
    @(posedge clk) disable iff (!resetn)
      (state_ff == MWSL_LOAD) && !addr_ok && !preset_all
        |=> $stable(wiper_value);
  endproperty
  a_bad_addr: assert property (p_bad_addr) // RULE18
    else $error("missing channel changed a latch");

  property p_preset_low;
    @(posedge clk) disable iff (!resetn)
      !pre_s |=> all_mid;
  endproperty
  a_preset_low: assert property (p_preset_low) // RULE9
    else $error("latches not midscale under preset");

  property p_preset_rise;
    @(posedge clk) disable iff (!resetn)
      $rose(pre_s) && cs_s |=> all_mid;
  endproperty
  a_preset_rise: assert property (p_preset_rise) // RULE10
    else $error("preset rise did not load midscale");

  property p_power_down;
    @(posedge clk) disable iff (!resetn)
      !pd_s && pre_s |=> !chain_out_oe && terminal_a_open && wiper_to_b
                         && $stable(wiper_value);
  endproperty
  a_power_down: assert property (p_power_down) // RULE11 RULE17
    else $error("power down not honoured");

  property p_open_drain;
    @(posedge clk) disable iff (!resetn)
      chain_out_o == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain) // RULE12
    else $error("chain output drove high");

endmodule

/* File: test/mwsl_host.sv */
// Host model driving the three-wire serial port of the loader
`timescale 1ns/100ps
module mwsl_host (
  // Serial link
  output logic sclk,
  output logic cs_n,
  output logic serial_in
);
  logic        chain_exp;
  logic [10:0] sent;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    serial_in = 1'b0;
    chain_exp = 1'b0;
    sent = 11'h000;
  end

  // ----------------------------------------------------------------
  // One frame, oldest bit first; clock stands low outside frames but for one stray pulse after each
  // ----------------------------------------------------------------
  task automatic frame(input logic [21:0] bits, input int n, input int hp);
    cs_n = 1'b0;
    #(hp);
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = bits[i];
      #(hp);
      chain_exp = sent[10];
      sent = {sent[9:0], bits[i]};
      sclk = 1'b1;
      #(hp);
      sclk = 1'b0;
    end
    #(hp);
    cs_n = 1'b1;
    // Released data line must not keep a plausible value
    serial_in = ~serial_in;
    // Stray edge while deselected must change nothing
    #(hp);
    sclk = 1'b1;
    #(hp);
    sclk = 1'b0;
    #(500);
  endtask
endmodule

/* File: test/tb_top.sv */
// Testbench of the serial wiper loader with a scoreboard queue
`timescale 1ns/100ps
module tb_top;
  import mwsl_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              clk;
  logic              resetn;
  logic              preset_n;
  logic              power_down_n;
  wire               sclk;
  wire               cs_n;
  wire               serial_in;
  logic              chain_out_o;
  logic              chain_out_oe;
  logic              terminal_a_open;
  logic              wiper_to_b;
  logic [BANK_W-1:0] wiper_value;
  logic [BANK_W-1:0] exp_bank;
  logic [BANK_W-1:0] exp_q[$];
  logic [7:0]        lf;
  logic              chk_chain;
  logic              exp_pin;
  int                fail_count;
  int                checked;
  // Open-drain pin with the host's pull-up
  wire               chain_pin = chain_out_oe ? chain_out_o : 1'b1;

  mwsl_host u_mwsl_host (.sclk(sclk), .cs_n(cs_n), .serial_in(serial_in));

  mwsl_loader #(.SIX_CHANNEL(1'b1)) u_mwsl_loader (
    .clk(clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n),
    .serial_in(serial_in), .chain_out_o(chain_out_o),
    .chain_out_oe(chain_out_oe), .preset_n(preset_n),
    .power_down_n(power_down_n), .terminal_a_open(terminal_a_open),
    .wiper_to_b(wiper_to_b), .wiper_value(wiper_value));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [BANK_W-1:0] seen,
                       input logic [BANK_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Only real changes are noted, since equal writes show nothing
  task automatic note(input logic [BANK_W-1:0] nb);
    if (nb !== exp_bank) begin
      exp_bank = nb;
      exp_q.push_back(nb);
    end
  endtask

  task automatic drain;
    for (int i = 0; i < 20 && exp_q.size() != 0; i++) @(posedge clk);
    if (exp_q.size() != 0) begin
      fail_count++;
      $display("[ERR] %0t no wiper update", $time);
      finish_test();
    end
  endtask

  task automatic pins(input logic pre, input logic pd);
    @(posedge clk);
    preset_n <= pre;
    power_down_n <= pd;
  endtask

  // Random junk above the word, random value below
  task automatic word(input logic [2:0] a, input int pre, input int hp,
                      input bit ok);
    logic [21:0]       b;
    logic [BANK_W-1:0] nb;
    lf = lfsr(lf);
    b = {lf, lf[2:0], a, lf};
    nb = exp_bank;
    if (ok && a < CH_SIX) nb[8*a +: 8] = lf;
    note(nb);
    u_mwsl_host.frame(b, 11 + pre, hp);
    drain();
  endtask

  // ----------------------------------------------------------------
  // Monitors
  // ----------------------------------------------------------------
  always @(wiper_value) begin
    if (resetn === 1'b1 && exp_q.size() != 0) begin
      check(wiper_value, exp_q.pop_front());
    end else if (resetn === 1'b1) begin
      fail_count++;
      $display("[ERR] %0t unexpected wiper change", $time);
    end
  end

  // Pin settles within three clk edges, well inside a slow half period
  always @(negedge sclk) begin
    // Pin is released while deselected, so only frames are compared
    if (chk_chain && !cs_n) begin
      exp_pin = power_down_n ? u_mwsl_host.chain_exp : 1'b1;
      check(BANK_W'(chain_pin), BANK_W'(exp_pin));
    end
  end

  initial begin
    #1000000;
    fail_count++;
    $display("[ERR] %0t run timed out", $time);
    finish_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    preset_n = 1'b1;
    power_down_n = 1'b1;
    lf = 8'h11;
    chk_chain = 1'b0;
    fail_count = 0;
    checked = 0;
    exp_bank = {NUM_CH{MIDSCALE}};
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    check(wiper_value, {NUM_CH{MIDSCALE}});
    check(BANK_W'(chain_out_oe), 48'h0);
    for (int a = 0; a < 8; a++) begin
      word(3'(a), 0, 24, 1'b1);
    end
    word(3'h2, 4, 24, 1'b1);
    chk_chain = 1'b1;
    word(3'h3, 11, 400, 1'b1);
    pins(1'b1, 1'b0);
    repeat (5) @(posedge clk);
    check(BANK_W'({terminal_a_open, wiper_to_b}), 48'h3);
    word(3'h1, 0, 400, 1'b0);
    chk_chain = 1'b0;
    pins(1'b1, 1'b1);
    repeat (5) @(posedge clk);
    check(BANK_W'({terminal_a_open, wiper_to_b}), 48'h0);
    check(wiper_value, exp_bank);
    note({NUM_CH{MIDSCALE}});
    pins(1'b0, 1'b1);
    drain();
    word(3'h0, 0, 24, 1'b0);
    pins(1'b1, 1'b1);
    repeat (6) @(posedge clk);
    check(wiper_value, {NUM_CH{MIDSCALE}});
    word(3'h5, 0, 24, 1'b1);
    finish_test();
  end
endmodule
